// [rtl/hpr_hibernation_power_rtc_unit.sv]
// hibernation power sequencer with seconds counter, events and retained words
//
// Contract
// [R1] power_hold_n low cuts chip supply, high restores it.
// [R2] while hibernating, an enabled pin or match wake releases power_hold_n.
// [R3] host spaces writes to counter, match, load, trim and memory registers.
// [R4] osc_select 0 divides crystal input by 128; 1 uses oscillator directly.
// [R5] reference tick path runs only while osc_enable is set.
// [R6] host waits crystal settling after osc_enable before other accesses.
// [R7] low battery with detection enabled sets battery_low_flag in raw status.
// [R8] abort enabled and low battery seen: power-down request is refused.
// [R9] battery is not evaluated while hibernated.
// [R10] 32-bit seconds counter advanced by a down-counting predivider.
// [R11] trim value divides one second in every 64; nominal 0x7FFF.
// [R12] trim above nominal lengthens that second, below shortens it.
// [R13] two 32-bit match compares, for wake or running event.
// [R14] counter advances only while seconds_counter_enable is set.
// [R15] counter_load write loads counter at any time.
// [R16] 64 retained 32-bit words, readable and writable, kept in hibernation.
// [R17] power_down_request starts hibernation unless aborted.
// [R18] host sets a wake source before requesting power-down.
// [R19] pin and match wake each have an enable; both may be set.
// [R20] enabled events are ORed onto one interrupt line.
// [R21] raw status shows pending events regardless of mask, wake kept.
// [R22] mask selects interrupt events; masked status is raw AND mask.
// [R23] writing one to event_clear clears that event; zero leaves it.
// [R24] match events sit at mask bits 1:0.
// [R25] match event raised when counter becomes equal to match value.
// [R26] register writes take effect within the write-spacing delay.
`timescale 1ns/1ps
`include "hpr_params.svh"

module hpr_hibernation_power_rtc_unit #(
    parameter int MEM_WORDS = `HPR_MEM_WORDS,
    parameter int XTAL_DIV = `HPR_XTAL_DIV
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [8:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // pins
    input wire logic xtal_in,
    input wire logic osc_in,
    input wire logic external_wake_n,
    input wire logic battery_low_in,
    // power and interrupt
    output logic power_hold_n,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // registers and state

    hpr_pkg::hpr_state_t state_r;
    hpr_pkg::hpr_ctl_t ctl_r;
    hpr_pkg::hpr_pins_t pin_s1, pin_s2, pin_s3, pin_lvl, pin_prev;
    logic [31:0] count_r, match0_r, match1_r, load_r;
    logic [15:0] trim_r, pre_r;
    logic [5:0] sec64_r;
    logic [6:0] xdiv_r;
    logic [3:0] mask_r, raw_r, raw_nxt, ev_set, ev_clr;
    logic [31:0] mem_r [MEM_WORDS];
    logic [31:0] rdata_r, rd_mux;
    logic hold_n_r, irq_r, eq0_r, eq1_r;

    assign reg_rdata = rdata_r;
    assign power_hold_n = hold_n_r;
    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    logic wr_ctl, wr_load, in_mem, req_go, abort_now;
    logic [5:0] mem_idx;
    logic [8:0] mem_off;

    // write strobes per register
    assign wr_ctl = reg_wr && (reg_addr == `HPR_OFF_CTL);
    assign wr_load = reg_wr && (reg_addr == `HPR_OFF_LOAD);
    assign mem_off = reg_addr - `HPR_OFF_MEM_LO;
    assign mem_idx = mem_off[7:2];
    assign in_mem = (reg_addr >= `HPR_OFF_MEM_LO) && (reg_addr <= `HPR_OFF_MEM_HI)
                    && (reg_addr[1:0] == 2'h0);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, level accepted when stages two and three agree

    logic [3:0] pins_raw;
    assign pins_raw = {battery_low_in, external_wake_n, osc_in, xtal_in};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pin_s1[gi] <= (gi == 2); // idle level, no false wake edge
                    pin_s2[gi] <= (gi == 2);
                    pin_s3[gi] <= (gi == 2);
                    pin_lvl[gi] <= (gi == 2);
                    pin_prev[gi] <= (gi == 2);
                end else begin
                    pin_s1[gi] <= pins_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    if (pin_s2[gi] == pin_s3[gi]) begin
                        pin_lvl[gi] <= pin_s3[gi];
                    end
                    pin_prev[gi] <= pin_lvl[gi];
                end
            end
        end
    endgenerate

    logic xtal_rise, osc_rise, wake_fall, ref_tick;
    assign xtal_rise = pin_lvl.xtal && !pin_prev.xtal;
    assign osc_rise = pin_lvl.osc && !pin_prev.osc;
    assign wake_fall = !pin_lvl.wake_n && pin_prev.wake_n;

    ////////////////////////////////////////////////////////////////////////
    // reference tick: crystal by 128 or oscillator direct

    // crystal edge divider, idle while the reference is off
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            xdiv_r <= 7'h00;
        end else if (!ctl_r.osc_en || ctl_r.osc_sel) begin
            xdiv_r <= 7'h00; // R5
        end else if (xtal_rise) begin
            xdiv_r <= xdiv_r + 7'h01; // R4
        end
    end

    assign ref_tick = ctl_r.osc_en && (ctl_r.osc_sel ? osc_rise // R5
                      : (xtal_rise && (xdiv_r == 7'(XTAL_DIV - 1)))); // R4

    ////////////////////////////////////////////////////////////////////////
    // predivider and seconds counter

    logic sec_tick;
    assign sec_tick = ref_tick && ctl_r.cnt_en && (pre_r == 16'h0000);

    // predivider counts down; one second in 64 reloads the trim value
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pre_r <= `HPR_RST_TRIM;
            sec64_r <= 6'h00;
        end else if (sec_tick) begin
            sec64_r <= sec64_r + 6'h01; // R11
            pre_r <= (sec64_r == `HPR_TRIM_SLOT) ? trim_r : `HPR_RST_TRIM; // R11 R12
        end else if (ref_tick && ctl_r.cnt_en) begin
            pre_r <= pre_r - 16'h0001; // R10
        end
    end

    // seconds counter, load wins over advance
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_r <= 32'h00000000;
        end else if (wr_load) begin
            count_r <= reg_wdata; // R15 R26
        end else if (sec_tick) begin
            count_r <= count_r + 32'h00000001; // R10 R14
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // match compare, event on becoming equal

    logic eq0, eq1, hit0, hit1;
    assign eq0 = (count_r == match0_r); // R13
    assign eq1 = (count_r == match1_r); // R13
    assign hit0 = eq0 && !eq0_r; // R25
    assign hit1 = eq1 && !eq1_r; // R25

    // previous equality
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            eq0_r <= 1'b0;
            eq1_r <= 1'b0;
        end else begin
            eq0_r <= eq0;
            eq1_r <= eq1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers

    // configuration writes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            match0_r <= `HPR_RST_MATCH;
            match1_r <= `HPR_RST_MATCH;
            load_r <= `HPR_RST_LOAD;
            trim_r <= `HPR_RST_TRIM;
            mask_r <= 4'h0;
            ctl_r <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                `HPR_OFF_MATCH0: match0_r <= reg_wdata; // R26
                `HPR_OFF_MATCH1: match1_r <= reg_wdata; // R26
                `HPR_OFF_LOAD: load_r <= reg_wdata; // R26
                `HPR_OFF_TRIM: trim_r <= reg_wdata[15:0]; // R26
                `HPR_OFF_MASK: mask_r <= reg_wdata[3:0]; // R22 R24
                `HPR_OFF_CTL: begin
                    ctl_r.cnt_en <= reg_wdata[`HPR_CTL_CNT_EN]; // R14
                    ctl_r.osc_sel <= reg_wdata[`HPR_CTL_OSC_SEL];
                    ctl_r.match_wake <= reg_wdata[`HPR_CTL_MATCH_WAKE]; // R19
                    ctl_r.pin_wake <= reg_wdata[`HPR_CTL_PIN_WAKE]; // R19
                    ctl_r.battery_low_flag_en <= reg_wdata[`HPR_CTL_BATTERY_LOW_FLAG_EN];
                    ctl_r.osc_en <= reg_wdata[`HPR_CTL_OSC_EN];
                    ctl_r.abort <= reg_wdata[`HPR_CTL_ABORT];
                end
                default: begin
                end
            endcase
        end
    end

    // retained words, no reset so contents survive
    always_ff @(posedge sys_clk) begin
        if (reg_wr && in_mem) begin
            mem_r[mem_idx] <= reg_wdata; // R16
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // events: sticky, set wins over clear

    always_comb begin
        ev_set = 4'h0;
        ev_set[`HPR_EV_MATCH0] = hit0; // R13
        ev_set[`HPR_EV_MATCH1] = hit1; // R13
        ev_set[`HPR_EV_BATTERY_LOW_FLAG] = ctl_r.battery_low_flag_en && pin_lvl.batt_low
                                 && (state_r == hpr_pkg::HPR_RUN); // R7 R9
        ev_set[`HPR_EV_WAKE] = wake_fall;
        ev_clr = (reg_wr && (reg_addr == `HPR_OFF_CLEAR)) ? reg_wdata[3:0] : 4'h0; // R23
        raw_nxt = (raw_r & ~ev_clr) | ev_set; // R21 R23
    end

    // raw status and interrupt line
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            raw_r <= 4'h0;
            irq_r <= 1'b0;
        end else begin
            raw_r <= raw_nxt; // R21
            irq_r <= |(raw_r & mask_r); // R20 R22
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power sequencer

    logic wake_go;
    assign req_go = wr_ctl && reg_wdata[`HPR_CTL_REQ]; // R17
    assign abort_now = reg_wdata[`HPR_CTL_ABORT] && raw_r[`HPR_EV_BATTERY_LOW_FLAG]; // R8
    assign wake_go = (ctl_r.pin_wake && !pin_lvl.wake_n)
                     || (ctl_r.match_wake && (hit0 || hit1)); // R2 R19

    // hold output follows the state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= hpr_pkg::HPR_RUN;
            hold_n_r <= 1'b1;
        end else begin
            case (state_r)
                hpr_pkg::HPR_RUN: begin
                    if (req_go && !abort_now) begin
                        state_r <= hpr_pkg::HPR_HIB; // R17
                        hold_n_r <= 1'b0; // R1
                    end
                end
                hpr_pkg::HPR_HIB: begin
                    if (wake_go) begin
                        state_r <= hpr_pkg::HPR_RUN; // R2
                        hold_n_r <= 1'b1; // R1
                    end
                end
                default: begin
                    state_r <= hpr_pkg::HPR_RUN;
                    hold_n_r <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, data in the cycle after the strobe

    always_comb begin
        rd_mux = 32'h00000000;
        if (in_mem) begin
            rd_mux = mem_r[mem_idx]; // R16
        end else begin
            case (reg_addr)
                `HPR_OFF_COUNT: rd_mux = count_r;
                `HPR_OFF_MATCH0: rd_mux = match0_r;
                `HPR_OFF_MATCH1: rd_mux = match1_r;
                `HPR_OFF_LOAD: rd_mux = load_r;
                `HPR_OFF_CTL: begin
                    rd_mux = `HPR_RST_CTL;
                    rd_mux[`HPR_CTL_CNT_EN] = ctl_r.cnt_en;
                    rd_mux[`HPR_CTL_OSC_SEL] = ctl_r.osc_sel;
                    rd_mux[`HPR_CTL_MATCH_WAKE] = ctl_r.match_wake;
                    rd_mux[`HPR_CTL_PIN_WAKE] = ctl_r.pin_wake;
                    rd_mux[`HPR_CTL_BATTERY_LOW_FLAG_EN] = ctl_r.battery_low_flag_en;
                    rd_mux[`HPR_CTL_OSC_EN] = ctl_r.osc_en;
                    rd_mux[`HPR_CTL_ABORT] = ctl_r.abort;
                end
                `HPR_OFF_MASK: rd_mux = {28'h0000000, mask_r};
                `HPR_OFF_RAW: rd_mux = {28'h0000000, raw_r}; // R21
                `HPR_OFF_MSK_ST: rd_mux = {28'h0000000, raw_r & mask_r}; // R22
                `HPR_OFF_TRIM: rd_mux = {16'h0000, trim_r};
                default: rd_mux = 32'h00000000;
            endcase
        end
    end

    // read data register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_r <= 32'h00000000;
        end else if (reg_rd) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_req_cuts: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == hpr_pkg::HPR_RUN && req_go && !abort_now)
        |=> !power_hold_n ##1 (!power_hold_n || $past(wake_go))) // R17
        else $error("power-down request did not assert hold");
    a_abort_keeps: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == hpr_pkg::HPR_RUN && req_go && abort_now) |=> power_hold_n) // R8
        else $error("aborted request still cut power");
    a_pin_wake: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == hpr_pkg::HPR_HIB && ctl_r.pin_wake && !pin_lvl.wake_n) |=> power_hold_n) // R2
        else $error("pin wake did not restore power");
    a_match_wake: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == hpr_pkg::HPR_HIB && ctl_r.match_wake && eq0 && !eq0_r) |=> power_hold_n) // R19
        else $error("match wake did not restore power");
    a_load_takes: assert property (@(posedge sys_clk) disable iff (rst)
        wr_load |=> (count_r == $past(reg_wdata))) // R15
        else $error("counter load not taken");
    a_count_still: assert property (@(posedge sys_clk) disable iff (rst)
        (!ctl_r.cnt_en && !wr_load) |=> $stable(count_r)) // R14
        else $error("counter moved while disabled");
    a_masked_read: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_rd && reg_addr == `HPR_OFF_MSK_ST) |=> (reg_rdata[3:0] == $past(raw_r & mask_r))) // R22
        else $error("masked status not raw and mask");
    a_clear_one: assert property (@(posedge sys_clk) disable iff (rst)
        (ev_clr[`HPR_EV_WAKE] && !wake_fall) |=> !raw_r[`HPR_EV_WAKE]) // R23
        else $error("clear did not remove wake event");
    a_batt_hib: assert property (@(posedge sys_clk) disable iff (rst)
        (state_r == hpr_pkg::HPR_HIB && !ev_clr[`HPR_EV_BATTERY_LOW_FLAG] && !raw_r[`HPR_EV_BATTERY_LOW_FLAG])
        |=> !raw_r[`HPR_EV_BATTERY_LOW_FLAG]) // R9
        else $error("battery evaluated while hibernated");
    a_irq_or: assert property (@(posedge sys_clk) disable iff (rst)
        (|(raw_r & mask_r)) |=> irq ##1 (irq || !$past(|(raw_r & mask_r)))) // R20
        else $error("enabled event did not raise interrupt");

    c_hib_cycle: cover property (@(posedge sys_clk) disable iff (rst)
        !power_hold_n ##[1:1000] power_hold_n);
    c_sec_tick: cover property (@(posedge sys_clk) disable iff (rst) sec_tick);
    c_match_irq: cover property (@(posedge sys_clk) disable iff (rst) hit0 ##[1:4] irq);
    c_abort: cover property (@(posedge sys_clk) disable iff (rst) req_go && abort_now);

endmodule // hpr_hibernation_power_rtc_unit

// [rtl/hpr_params.svh]
// constants of the hibernation power and seconds-counter unit
`ifndef HPR_PARAMS_SVH
`define HPR_PARAMS_SVH
// register byte offsets
`define HPR_OFF_COUNT 9'h000
`define HPR_OFF_MATCH0 9'h004
`define HPR_OFF_MATCH1 9'h008
`define HPR_OFF_LOAD 9'h00C
`define HPR_OFF_CTL 9'h010
`define HPR_OFF_MASK 9'h014
`define HPR_OFF_RAW 9'h018
`define HPR_OFF_MSK_ST 9'h01C
`define HPR_OFF_CLEAR 9'h020
`define HPR_OFF_TRIM 9'h024
`define HPR_OFF_MEM_LO 9'h030
`define HPR_OFF_MEM_HI 9'h12C
// power_control bit positions
`define HPR_CTL_CNT_EN 0
`define HPR_CTL_REQ 1
`define HPR_CTL_OSC_SEL 2
`define HPR_CTL_MATCH_WAKE 3
`define HPR_CTL_PIN_WAKE 4
`define HPR_CTL_BATTERY_LOW_FLAG_EN 5
`define HPR_CTL_OSC_EN 6
`define HPR_CTL_ABORT 7
// event bit positions
`define HPR_EV_MATCH0 0
`define HPR_EV_MATCH1 1
`define HPR_EV_BATTERY_LOW_FLAG 2
`define HPR_EV_WAKE 3
`define HPR_EV_W 4
// reset values
`define HPR_RST_MATCH 32'hFFFFFFFF
`define HPR_RST_LOAD 32'hFFFFFFFF
`define HPR_RST_CTL 32'h80000000
`define HPR_RST_TRIM 16'h7FFF
// timing counts
`define HPR_XTAL_DIV 128
`define HPR_TRIM_SLOT 6'h3E
`define HPR_MEM_WORDS 64
`endif

// [rtl/hpr_pkg.sv]
// types of the hibernation power and seconds-counter unit
package hpr_pkg;
    // power sequencer states, one-hot
    typedef enum logic [1:0] {
        HPR_RUN = 2'b01,
        HPR_HIB = 2'b10
    } hpr_state_t;
    // software control fields
    typedef struct packed {
        logic abort;
        logic osc_en;
        logic battery_low_flag_en;
        logic pin_wake;
        logic match_wake;
        logic osc_sel;
        logic cnt_en;
    } hpr_ctl_t;
    // synchronised pin levels
    typedef struct packed {
        logic batt_low;
        logic wake_n;
        logic osc;
        logic xtal;
    } hpr_pins_t;
endpackage

// [verif/hpr_partner.sv]
// partner model: regulator, wake pin source, battery comparator and clock sources
`timescale 1ns/1ps

module hpr_partner (
    // clock
    input wire logic sys_clk,
    // commands from the bench
    input wire logic wake_cmd,
    input wire logic batt_cmd,
    // device pins
    input wire logic power_hold_n,
    output logic xtal_in,
    output logic osc_in,
    output logic external_wake_n,
    output logic battery_low_in,
    // regulator status
    output logic supply_on
);
    logic [2:0] div_cnt = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // free-running sources; oscillator period is 8 sys_clk, above the sync limit
    initial begin
        xtal_in = 1'b0;
        osc_in = 1'b0;
        supply_on = 1'b1;
    end
    always @(posedge sys_clk) begin
        div_cnt <= div_cnt + 3'h1;
        xtal_in <= div_cnt[0];
        osc_in <= div_cnt[2];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // weak pull-up holds the wake pin high while the source is released
    assign external_wake_n = wake_cmd ? 1'b0 : 1'b1;
    assign battery_low_in = batt_cmd;

    // regulator enable: low cuts the supply, high restores it
    always @(posedge sys_clk) begin
        supply_on <= power_hold_n;
    end
endmodule // hpr_partner

// [verif/hpr_hibernation_power_rtc_unit_tb.sv]
// self-checking bench of the hibernation power and seconds-counter unit
`timescale 1ns/1ps
`include "hpr_params.svh"

module hpr_hibernation_power_rtc_unit_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [8:0] reg_addr = 9'h000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic xtal_in;
    logic osc_in;
    logic external_wake_n;
    logic battery_low_in;
    logic power_hold_n;
    logic irq;
    logic supply_on;
    logic wake_cmd = 1'b0;
    logic batt_cmd = 1'b0;
    logic [31:0] rd_val;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // design and far-side model
    hpr_hibernation_power_rtc_unit dut_u (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xtal_in(xtal_in),
        .osc_in(osc_in), .external_wake_n(external_wake_n), .battery_low_in(battery_low_in),
        .power_hold_n(power_hold_n), .irq(irq)
    );
    hpr_partner partner_u (
        .sys_clk(sys_clk), .wake_cmd(wake_cmd), .batt_cmd(batt_cmd), .power_hold_n(power_hold_n),
        .xtal_in(xtal_in), .osc_in(osc_in), .external_wake_n(external_wake_n),
        .battery_low_in(battery_low_in), .supply_on(supply_on)
    );

    // 200 MHz clock
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shared compare and bus cycles
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // write, then the spacing the host owes the slow domain
    task automatic reg_write(input logic [8:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic read_check(input string what, input logic [8:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
        check(what, exp, rd_val);
    endtask

    // bounded wait for the regulator control level
    task automatic wait_hold(input logic exp, input int limit);
        int n = 0;
        while (power_hold_n !== exp && n < limit) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("power_hold_n", {31'h0, exp}, {31'h0, power_hold_n});
    endtask

    task automatic pins(input logic w, input logic b, input int gap);
        @(posedge sys_clk);
        wake_cmd <= w;
        batt_cmd <= b;
        repeat (gap) @(posedge sys_clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        check("hold at reset", 32'h1, {31'h0, power_hold_n});
        check("irq at reset", 32'h0, {31'h0, irq});
        read_check("count", `HPR_OFF_COUNT, 32'h00000000);
        read_check("match0", `HPR_OFF_MATCH0, `HPR_RST_MATCH);
        read_check("match1", `HPR_OFF_MATCH1, `HPR_RST_MATCH);
        read_check("load", `HPR_OFF_LOAD, `HPR_RST_LOAD);
        read_check("control", `HPR_OFF_CTL, `HPR_RST_CTL);
        read_check("mask", `HPR_OFF_MASK, 32'h00000000);
        read_check("raw", `HPR_OFF_RAW, 32'h00000000);
        read_check("masked", `HPR_OFF_MSK_ST, 32'h00000000);
        read_check("clear", `HPR_OFF_CLEAR, 32'h00000000);
        read_check("trim", `HPR_OFF_TRIM, 32'h00007FFF);
        read_check("unmapped", 9'h028, 32'h00000000);
    endtask

    task automatic t_regs();
        reg_write(`HPR_OFF_MATCH0, 32'hA5A55A5A);
        reg_write(`HPR_OFF_MATCH1, 32'h0123ABCD);
        reg_write(`HPR_OFF_TRIM, 32'h00008123);
        reg_write(`HPR_OFF_MASK, 32'hFFFFFFFF);
        reg_write(`HPR_OFF_MEM_LO, 32'hDEADBEEF);
        reg_write(`HPR_OFF_MEM_HI, 32'h13579BDF);
        read_check("match0", `HPR_OFF_MATCH0, 32'hA5A55A5A);
        read_check("match1", `HPR_OFF_MATCH1, 32'h0123ABCD);
        read_check("trim", `HPR_OFF_TRIM, 32'h00008123);
        read_check("mask width", `HPR_OFF_MASK, 32'h0000000F);
        read_check("first word", `HPR_OFF_MEM_LO, 32'hDEADBEEF);
        read_check("last word", `HPR_OFF_MEM_HI, 32'h13579BDF);
        reg_write(`HPR_OFF_TRIM, 32'h00007FFF);
    endtask

    task automatic t_match();
        reg_write(`HPR_OFF_CTL, 32'h00000044);
        reg_write(`HPR_OFF_MASK, 32'h00000001);
        reg_write(`HPR_OFF_MATCH0, 32'h00000010);
        reg_write(`HPR_OFF_MATCH1, 32'h00000020);
        reg_write(`HPR_OFF_LOAD, 32'h00000010);
        read_check("count after load", `HPR_OFF_COUNT, 32'h00000010);
        read_check("raw match0", `HPR_OFF_RAW, 32'h00000001);
        check("irq match0", 32'h1, {31'h0, irq});
        reg_write(`HPR_OFF_LOAD, 32'h00000020);
        read_check("raw both", `HPR_OFF_RAW, 32'h00000003);
        reg_write(`HPR_OFF_MASK, 32'h00000002);
        read_check("masked", `HPR_OFF_MSK_ST, 32'h00000002);
        reg_write(`HPR_OFF_CLEAR, 32'h00000001);
        read_check("raw after clear", `HPR_OFF_RAW, 32'h00000002);
        check("irq still", 32'h1, {31'h0, irq});
        reg_write(`HPR_OFF_CLEAR, 32'h00000002);
        read_check("raw cleared", `HPR_OFF_RAW, 32'h00000000);
        check("irq low", 32'h0, {31'h0, irq});
        read_check("count held", `HPR_OFF_COUNT, 32'h00000020);
    endtask

    task automatic t_battery();
        pins(1'b0, 1'b1, 8);
        read_check("raw no detect", `HPR_OFF_RAW, 32'h00000000);
        reg_write(`HPR_OFF_CTL, 32'h00000064);
        read_check("raw battery", `HPR_OFF_RAW, 32'h00000004);
        reg_write(`HPR_OFF_CTL, 32'h000000F6);
        pins(1'b0, 1'b1, 8);
        check("hold aborted", 32'h1, {31'h0, power_hold_n});
        check("supply kept", 32'h1, {31'h0, supply_on});
        pins(1'b0, 1'b0, 8);
        reg_write(`HPR_OFF_CLEAR, 32'h00000004);
        read_check("raw battery cleared", `HPR_OFF_RAW, 32'h00000000);
    endtask

    task automatic t_pin_wake();
        reg_write(`HPR_OFF_CTL, 32'h00000076);
        check("hold cut", 32'h0, {31'h0, power_hold_n});
        check("supply cut", 32'h0, {31'h0, supply_on});
        pins(1'b0, 1'b1, 10);
        read_check("raw while hibernated", `HPR_OFF_RAW, 32'h00000000);
        pins(1'b0, 1'b0, 20);
        check("hold kept low", 32'h0, {31'h0, power_hold_n});
        pins(1'b1, 1'b0, 0);
        wait_hold(1'b1, 8);
        read_check("raw wake", `HPR_OFF_RAW, 32'h00000008);
        read_check("word kept", `HPR_OFF_MEM_LO, 32'hDEADBEEF);
        pins(1'b0, 1'b0, 6);
        reg_write(`HPR_OFF_CLEAR, 32'h00000008);
    endtask

    task automatic t_match_wake();
        reg_write(`HPR_OFF_MATCH0, 32'h00000040);
        reg_write(`HPR_OFF_CTL, 32'h0000004E);
        check("hold cut", 32'h0, {31'h0, power_hold_n});
        pins(1'b1, 1'b0, 10);
        check("pin wake off", 32'h0, {31'h0, power_hold_n});
        pins(1'b0, 1'b0, 6);
        reg_write(`HPR_OFF_LOAD, 32'h00000040);
        wait_hold(1'b1, 8);
        read_check("raw match wake", `HPR_OFF_RAW, 32'h00000009);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and run end
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            $display("unexpected cycle count: expected below 5000, seen %0d", cyc);
            end_sim();
        end
    end

    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_match();
        t_battery();
        t_pin_wake();
        t_match_wake();
        end_sim();
    end
endmodule // hpr_hibernation_power_rtc_unit_tb
